// [hw/io_timer_block.v]
// pin synchronizer, level-detect latches, byte buffers and two timer/counters
// assumes: one 250 MHz clock, register master on the same clock, pins asynchronous
`timescale 1ns/1ns
`include "io_timer_defines.vh"

// Overview of operation
// - port pins pass a synchronizer on the system clock before timer use and pin reads.
// - system clock runs at input clock divided by two.
// - software reads the current synchronized level; fast interim changes are lost.
// - parallel slave select rising edges are caught without the synchronizer.
// - low levels on pins 0-7 latched on a 200 ns sample clock until cleared.
// - serial and SPI ports hold whole received and transmitted bytes for transfer.
// - timer input modes measure in hardware into a readable latch.
// - high-time and period modes measure pulse width and period.
// - windowed edge count counts rising edges within a fixed window.
// - quadrature mode accumulates signed Gray-code steps, clamped to +/-16383.
// - edge log records interval between successive transitions on its pin.
// - dual-slope mode drives control out and times comparator input.
// - infrared demod mode times falling-edge intervals and classifies bits.
// - divider output frequency equals input frequency over the divisor.
// - square wave mode toggles output every programmed tick count plus one.
// - single-pulse mode emits one pulse of programmed length plus one tick.
// - duty mode gives zero to full duty pulse train.
// - phase mode pulses output a programmed delay after each sync edge.
// - edge-gated mode holds output until programmed edge count reached.
// - infrared pattern mode repeats timed square-wave bursts.
// - each timer has byte-accessed 16-bit load, aux and latch.
module io_timer_block #(
	parameter CNT_W = 16,
	parameter WINDOW_CYC = `EDGE_WINDOW_NS / (`CLK_PERIOD_NS * `SYS_DIV)
) (
	input wire clk_i,
	input wire srst_i,
	input wire ce_i,
	input wire [11:0] pins_i,
	input wire pss_i,
	input wire [7:0] addr_i,
	input wire [7:0] wdata_i,
	input wire we_i,
	input wire re_i,
	output reg [7:0] rdata_o,
	output wire tmr0_out_o,
	output wire tmr1_out_o,
	input wire [7:0] asp_rx_data_i,
	input wire asp_rx_stb_i,
	output wire [7:0] asp_tx_data_o,
	output wire asp_tx_valid_o,
	input wire asp_tx_take_i,
	output wire asp_xfer_req_o,
	input wire [7:0] spi_rx_data_i,
	input wire spi_rx_stb_i,
	output wire [7:0] spi_tx_data_o,
	output wire spi_tx_valid_o,
	input wire spi_tx_take_i,
	output wire spi_xfer_req_o
);

	localparam [7:0] LVL_CYC = `LVL_SAMPLE_NS / `CLK_PERIOD_NS;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	// timer register hit
	function is_treg;
		input [7:0] a;
		input integer t;
		input [7:0] off;
		begin
			is_treg = (a == (`TMR_BASE + t[7:0] * `TMR_STRIDE + off));
		end
	endfunction

	// byte buffer register hit
	function is_breg;
		input [7:0] a;
		input integer k;
		input [7:0] off;
		begin
			is_breg = (a == (`BUF_BASE + k[7:0] * `BUF_STRIDE + off));
		end
	endfunction

	// prescaled tick from free counter
	function ptick;
		input [2:0] p;
		input [7:0] c;
		reg [7:0] m;
		begin
			m = (8'h01 << p) - 8'h01;
			ptick = ((c & m) == m);
		end
	endfunction

	// saturating increment
	function [CNT_W-1:0] inc_sat;
		input [CNT_W-1:0] v;
		begin
			inc_sat = (&v) ? v : v + 1'b1;
		end
	endfunction

	// ----------------------------------------------------------------
	// system clock enable and synchronizer
	// ----------------------------------------------------------------
	reg div;
	reg [11:0] sync1;
	reg [11:0] sync2;
	reg [11:0] prev;
	reg [7:0] psc_cnt;
	wire sys_ce = ce_i & div;

	// half-rate enable, two-stage pin capture, edge reference
	always @(posedge clk_i) begin
		if (srst_i) begin
			div <= 1'b0;
			sync1 <= 12'h000;
			sync2 <= 12'h000;
			prev <= 12'h000;
			psc_cnt <= 8'h00;
		end else if (ce_i) begin
			div <= ~div;
			if (div) begin
				sync1 <= pins_i;
				sync2 <= sync1;
				prev <= sync2;
				psc_cnt <= psc_cnt + 8'h01;
			end
		end
	end

	wire [11:0] rise = sync2 & ~prev;
	wire [11:0] fall = ~sync2 & prev;

	// ----------------------------------------------------------------
	// edge-count window
	// ----------------------------------------------------------------
	reg [31:0] win_cnt;
	reg win_end;

	// free window of fixed length in system ticks
	always @(posedge clk_i) begin
		if (srst_i) begin
			win_cnt <= 32'h00000000;
			win_end <= 1'b0;
		end else if (ce_i) begin
			win_end <= 1'b0;
			if (sys_ce) begin
				if (win_cnt >= WINDOW_CYC - 1) begin
					win_cnt <= 32'h00000000;
					win_end <= 1'b1;
				end else begin
					win_cnt <= win_cnt + 32'h00000001;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// level-detect latches
	// ----------------------------------------------------------------
	reg [7:0] lvl_div;
	reg [7:0] lvl_samp;
	reg [7:0] lvl_samp2;
	reg [7:0] lvl_latch;

	// 200 ns sample flop, then sticky low capture
	always @(posedge clk_i) begin
		if (srst_i) begin
			lvl_div <= 8'h00;
			lvl_samp <= 8'hff;
			lvl_samp2 <= 8'hff;
			lvl_latch <= 8'h00;
		end else if (ce_i) begin
			if (lvl_div >= LVL_CYC - 8'h01) begin
				lvl_div <= 8'h00;
				lvl_samp <= pins_i[7:0];
			end else begin
				lvl_div <= lvl_div + 8'h01;
			end
			lvl_samp2 <= lvl_samp;
			if (we_i && addr_i == `ADDR_LVL_LATCH)
				lvl_latch <= (lvl_latch & ~wdata_i) | ~lvl_samp2;
			else
				lvl_latch <= lvl_latch | ~lvl_samp2;
		end
	end

	// ----------------------------------------------------------------
	// parallel slave select edge capture
	// ----------------------------------------------------------------
	reg pss_tog;
	reg pss_s1;
	reg pss_s2;
	reg pss_s3;
	reg pss_seen;

	// edge toggles a flop clocked by the pin itself
	always @(posedge pss_i or posedge srst_i) begin
		if (srst_i)
			pss_tog <= 1'b0;
		else
			pss_tog <= ~pss_tog;
	end

	// toggle crosses by two flops, change marks one edge
	always @(posedge clk_i) begin
		if (srst_i) begin
			pss_s1 <= 1'b0;
			pss_s2 <= 1'b0;
			pss_s3 <= 1'b0;
			pss_seen <= 1'b0;
		end else if (ce_i) begin
			pss_s1 <= pss_tog;
			pss_s2 <= pss_s1;
			pss_s3 <= pss_s2;
			if (pss_s2 ^ pss_s3)
				pss_seen <= 1'b1;
			else if (we_i && addr_i == `ADDR_PSS_EDGE && wdata_i[0])
				pss_seen <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// timer/counters
	// ----------------------------------------------------------------
	wire [15:0] t_rd;
	wire [1:0] t_hit;
	wire [1:0] t_out;
	assign tmr0_out_o = t_out[0];
	assign tmr1_out_o = t_out[1];

	genvar t;
	generate
		for (t = 0; t < 2; t = t + 1) begin : g_tmr
			reg [7:0] ctrl;
			reg [2:0] presc;
			reg [CNT_W-1:0] load;
			reg [CNT_W-1:0] aux;
			reg [CNT_W-1:0] cnt;
			reg [CNT_W-1:0] cnt2;
			reg [CNT_W-1:0] latch;
			reg [7:0] shadow;
			reg ready;
			reg outr;
			reg run;
			reg burst;
			reg phase;
			reg irbit;
			reg [7:0] rd;
			wire [1:0] sel = (t == 0) ? ctrl[`CTRL_SEL] : 2'b00;
			wire [3:0] mode = ctrl[`CTRL_MODE];
			wire [3:0] pa = 4'h4 + {2'b00, sel};
			wire [3:0] qa = 4'h4 + {2'b00, sel[1], 1'b0};
			wire lvl = sync2[pa];
			wire r_e = sys_ce & rise[pa];
			wire f_e = sys_ce & fall[pa];
			wire qa_n = sync2[qa];
			wire qb_n = sync2[qa + 4'h1];
			wire qa_p = prev[qa];
			wire qb_p = prev[qa + 4'h1];
			wire k = sys_ce & ptick(presc, psc_cnt);
			wire go = we_i & is_treg(addr_i, t, `TR_STAT) & wdata_i[`STAT_GO];
			wire clr = (we_i & is_treg(addr_i, t, `TR_STAT) & wdata_i[`STAT_CLR]) |
				(re_i & is_treg(addr_i, t, `TR_LATCH_LO));
			assign t_out[t] = outr;
			assign t_rd[t*8 +: 8] = rd;
			assign t_hit[t] = (addr_i >= `TMR_BASE + t * `TMR_STRIDE) &&
				(addr_i <= `TMR_BASE + t * `TMR_STRIDE + `TR_STAT);

			// register read view
			always @* begin
				rd = 8'h00;
				if (is_treg(addr_i, t, `TR_CTRL)) rd = ctrl;
				if (is_treg(addr_i, t, `TR_PRESC)) rd = {5'h00, presc};
				if (is_treg(addr_i, t, `TR_LOAD_LO)) rd = load[7:0];
				if (is_treg(addr_i, t, `TR_LOAD_HI)) rd = load[15:8];
				if (is_treg(addr_i, t, `TR_AUX_LO)) rd = aux[7:0];
				if (is_treg(addr_i, t, `TR_AUX_HI)) rd = aux[15:8];
				if (is_treg(addr_i, t, `TR_LATCH_LO)) rd = latch[7:0];
				if (is_treg(addr_i, t, `TR_LATCH_HI)) rd = shadow;
				if (is_treg(addr_i, t, `TR_STAT)) rd = {4'h0, irbit, run, outr, ready};
			end

			// byte-wide setup and mode engine
			always @(posedge clk_i) begin
				if (srst_i) begin
					ctrl <= 8'h00;
					presc <= 3'h0;
					load <= {CNT_W{1'b0}};
					aux <= {CNT_W{1'b0}};
					cnt <= {CNT_W{1'b0}};
					cnt2 <= {CNT_W{1'b0}};
					latch <= {CNT_W{1'b0}};
					shadow <= 8'h00;
					ready <= 1'b0;
					outr <= 1'b0;
					run <= 1'b0;
					burst <= 1'b0;
					phase <= 1'b0;
					irbit <= 1'b0;
				end else if (ce_i) begin
					if (we_i && is_treg(addr_i, t, `TR_PRESC)) presc <= wdata_i[2:0];
					if (we_i && is_treg(addr_i, t, `TR_LOAD_LO)) load[7:0] <= wdata_i;
					if (we_i && is_treg(addr_i, t, `TR_LOAD_HI)) load[15:8] <= wdata_i;
					if (we_i && is_treg(addr_i, t, `TR_AUX_LO)) aux[7:0] <= wdata_i;
					if (we_i && is_treg(addr_i, t, `TR_AUX_HI)) aux[15:8] <= wdata_i;
					if (re_i && is_treg(addr_i, t, `TR_LATCH_LO)) shadow <= latch[15:8];
					if (clr) ready <= 1'b0;
					if (we_i && is_treg(addr_i, t, `TR_CTRL)) begin
						ctrl <= wdata_i;
						cnt <= {CNT_W{1'b0}};
						cnt2 <= {CNT_W{1'b0}};
						run <= 1'b0;
						outr <= 1'b0;
						burst <= 1'b0;
						phase <= 1'b0;
					end else begin
						case (mode)
						`MODE_HIGH_TIME: begin
							if (r_e) cnt <= {CNT_W{1'b0}};
							else if (lvl && k) cnt <= inc_sat(cnt);
							if (f_e) begin
								latch <= cnt;
								ready <= 1'b1;
							end
						end
						`MODE_PERIOD: begin
							if (r_e) begin
								latch <= cnt;
								ready <= 1'b1;
								cnt <= {CNT_W{1'b0}};
							end else if (k) cnt <= inc_sat(cnt);
						end
						`MODE_WIN_COUNT: begin
							if (win_end) begin
								latch <= cnt;
								ready <= 1'b1;
								cnt <= {CNT_W{1'b0}};
							end else if (r_e) cnt <= inc_sat(cnt);
						end
						`MODE_QUAD: begin
							if (sys_ce && ((qa_n ^ qa_p) || (qb_n ^ qb_p))) begin
								ready <= 1'b1;
								if (qa_n ^ qb_p) begin
									if (cnt != `QUAD_LIMIT) cnt <= cnt + 1'b1;
								end else begin
									if (cnt != `QUAD_NEG_LIMIT) cnt <= cnt - 1'b1;
								end
							end
							latch <= cnt;
						end
						`MODE_EDGE_LOG: begin
							if (r_e || f_e) begin
								latch <= cnt;
								ready <= 1'b1;
								irbit <= lvl;
								cnt <= {CNT_W{1'b0}};
							end else if (k) cnt <= inc_sat(cnt);
						end
						`MODE_DUAL_SLOPE: begin
							if (go) begin
								outr <= 1'b1;
								run <= 1'b1;
								cnt <= {CNT_W{1'b0}};
							end else if (run && f_e) begin
								latch <= cnt;
								ready <= 1'b1;
								outr <= 1'b0;
								run <= 1'b0;
							end else if (run && k) cnt <= inc_sat(cnt);
						end
						`MODE_IR_DEMOD: begin
							if (f_e) begin
								latch <= cnt;
								irbit <= (cnt > aux);
								ready <= 1'b1;
								cnt <= {CNT_W{1'b0}};
							end else if (k) cnt <= inc_sat(cnt);
						end
						`MODE_FREQ_DIV: begin
							if (r_e || f_e) begin
								if (cnt + 1'b1 >= load) begin
									cnt <= {CNT_W{1'b0}};
									outr <= ~outr;
								end else cnt <= cnt + 1'b1;
							end
						end
						`MODE_SQUARE: begin
							if (k) begin
								if (cnt >= load) begin
									cnt <= {CNT_W{1'b0}};
									outr <= ~outr;
								end else cnt <= cnt + 1'b1;
							end
						end
						`MODE_ONESHOT: begin
							// rise on the first tick after go, so width is whole ticks
							if (go) begin
								run <= 1'b1;
								cnt <= {CNT_W{1'b0}};
							end else if (run && k) begin
								outr <= 1'b1;
								if (outr && cnt >= load) begin
									outr <= 1'b0;
									run <= 1'b0;
								end else if (outr) cnt <= cnt + 1'b1;
							end
						end
						`MODE_DUTY: begin
							if (k) begin
								cnt <= (cnt >= aux) ? {CNT_W{1'b0}} : cnt + 1'b1;
								outr <= (cnt < load);
							end
						end
						`MODE_PHASE: begin
							if (r_e) begin
								run <= 1'b1;
								cnt <= {CNT_W{1'b0}};
							end else if (run && k) begin
								if (cnt >= load) begin
									outr <= 1'b1;
									run <= 1'b0;
								end else cnt <= cnt + 1'b1;
							end else if (outr && k) outr <= 1'b0;
						end
						`MODE_EDGE_GATE: begin
							if (go) begin
								outr <= 1'b1;
								run <= 1'b1;
								cnt <= {CNT_W{1'b0}};
							end else if (run && r_e) begin
								if (cnt + 1'b1 >= load) begin
									outr <= 1'b0;
									run <= 1'b0;
									ready <= 1'b1;
								end else cnt <= cnt + 1'b1;
							end
						end
						`MODE_IR_PATTERN: begin
							if (go) run <= 1'b1;
							if (run && k) begin
								if (cnt2 >= aux) begin
									cnt2 <= {CNT_W{1'b0}};
									phase <= ~phase;
								end else cnt2 <= cnt2 + 1'b1;
								if (cnt >= load) begin
									cnt <= {CNT_W{1'b0}};
									burst <= ~burst;
								end else cnt <= cnt + 1'b1;
								outr <= ~burst & phase;
							end
						end
						default: begin
							outr <= 1'b0;
						end
						endcase
					end
				end
			end
		end
	endgenerate

	// ----------------------------------------------------------------
	// byte buffers for serial and SPI ports
	// ----------------------------------------------------------------
	wire [1:0] rx_stb = {spi_rx_stb_i, asp_rx_stb_i};
	wire [15:0] rx_dat = {spi_rx_data_i, asp_rx_data_i};
	wire [1:0] tx_take = {spi_tx_take_i, asp_tx_take_i};
	wire [15:0] b_rd;
	wire [15:0] tx_dat;
	wire [1:0] tx_vld;
	wire [1:0] rx_ful;
	assign asp_tx_data_o = tx_dat[7:0];
	assign spi_tx_data_o = tx_dat[15:8];
	assign asp_tx_valid_o = tx_vld[0];
	assign spi_tx_valid_o = tx_vld[1];
	assign asp_xfer_req_o = rx_ful[0];
	assign spi_xfer_req_o = rx_ful[1];

	genvar b;
	generate
		for (b = 0; b < 2; b = b + 1) begin : g_buf
			reg [7:0] rx_byte;
			reg rx_full;
			reg rx_ovr;
			reg [7:0] tx_byte;
			reg tx_valid;
			assign tx_dat[b*8 +: 8] = tx_byte;
			assign tx_vld[b] = tx_valid;
			assign rx_ful[b] = rx_full;
			assign b_rd[b*8 +: 8] = is_breg(addr_i, b, `BR_RX) ? rx_byte :
				is_breg(addr_i, b, `BR_STAT) ? {5'h00, rx_ovr, tx_valid, rx_full} : 8'h00;

			// whole-byte hold in each direction, arrival beats read clear
			always @(posedge clk_i) begin
				if (srst_i) begin
					rx_byte <= 8'h00;
					rx_full <= 1'b0;
					rx_ovr <= 1'b0;
					tx_byte <= 8'h00;
					tx_valid <= 1'b0;
				end else if (ce_i) begin
					if (re_i && is_breg(addr_i, b, `BR_RX)) rx_full <= 1'b0;
					if (we_i && is_breg(addr_i, b, `BR_STAT) && wdata_i[2]) rx_ovr <= 1'b0;
					if (rx_stb[b]) begin
						rx_byte <= rx_dat[b*8 +: 8];
						rx_full <= 1'b1;
						if (rx_full) rx_ovr <= 1'b1;
					end
					if (tx_take[b]) tx_valid <= 1'b0;
					if (we_i && is_breg(addr_i, b, `BR_TX)) begin
						tx_byte <= wdata_i;
						tx_valid <= 1'b1;
					end
				end
			end
		end
	endgenerate

	// ----------------------------------------------------------------
	// read data
	// ----------------------------------------------------------------
	// registered read one cycle after strobe, zero otherwise
	always @(posedge clk_i) begin
		if (srst_i) begin
			rdata_o <= 8'h00;
		end else if (ce_i) begin
			rdata_o <= 8'h00;
			if (re_i) begin
				case (addr_i)
				`ADDR_PIN_LO: rdata_o <= sync2[7:0];
				`ADDR_PIN_HI: rdata_o <= {4'h0, sync2[11:8]};
				`ADDR_LVL_LATCH: rdata_o <= lvl_latch;
				`ADDR_PSS_EDGE: rdata_o <= {7'h00, pss_seen};
				default: begin
					if (t_hit[0]) rdata_o <= t_rd[7:0];
					else if (t_hit[1]) rdata_o <= t_rd[15:8];
					else rdata_o <= b_rd[7:0] | b_rd[15:8];
				end
				endcase
			end
		end
	end

endmodule

// [pkg/io_timer_defines.vh]
// constants for the pin conditioning and timer/counter block
// assumes: included by the design file and the property checker, 8-bit register port
`ifndef IO_TIMER_DEFINES_VH
`define IO_TIMER_DEFINES_VH

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CLK_PERIOD_NS 4
`define SYS_DIV 2
`define LVL_SAMPLE_NS 200
`define EDGE_WINDOW_NS 839000000

// ----------------------------------------------------------------
// timer modes
// ----------------------------------------------------------------
`define MODE_OFF 4'h0
`define MODE_HIGH_TIME 4'h1
`define MODE_PERIOD 4'h2
`define MODE_WIN_COUNT 4'h3
`define MODE_QUAD 4'h4
`define MODE_EDGE_LOG 4'h5
`define MODE_DUAL_SLOPE 4'h6
`define MODE_IR_DEMOD 4'h7
`define MODE_FREQ_DIV 4'h8
`define MODE_SQUARE 4'h9
`define MODE_ONESHOT 4'ha
`define MODE_DUTY 4'hb
`define MODE_PHASE 4'hc
`define MODE_EDGE_GATE 4'hd
`define MODE_IR_PATTERN 4'he

// ----------------------------------------------------------------
// register map
// ----------------------------------------------------------------
`define ADDR_PIN_LO 8'h00
`define ADDR_PIN_HI 8'h01
`define ADDR_LVL_LATCH 8'h02
`define ADDR_PSS_EDGE 8'h03
`define TMR_BASE 8'h10
`define TMR_STRIDE 8'h10
`define TR_CTRL 8'h00
`define TR_PRESC 8'h01
`define TR_LOAD_LO 8'h02
`define TR_LOAD_HI 8'h03
`define TR_AUX_LO 8'h04
`define TR_AUX_HI 8'h05
`define TR_LATCH_LO 8'h06
`define TR_LATCH_HI 8'h07
`define TR_STAT 8'h08
`define BUF_BASE 8'h40
`define BUF_STRIDE 8'h04
`define BR_RX 8'h00
`define BR_TX 8'h01
`define BR_STAT 8'h02

// ----------------------------------------------------------------
// fields
// ----------------------------------------------------------------
`define CTRL_MODE 3:0
`define CTRL_SEL 5:4
`define STAT_GO 0
`define STAT_CLR 1
`define QUAD_LIMIT 16'h3fff
`define QUAD_NEG_LIMIT 16'hc001

`endif

// [tb/pin_source.sv]
// partner model: outside signal sources on the port pins and slave select
// assumes: called from the bench, pins idle high through pull-ups
`timescale 1ns/1ns
module pin_source (
	input wire clk_i,
	output logic [11:0] pins_o,
	output logic pss_o
);
	initial begin
		pins_o = 12'hfff;
		pss_o = 1'b0;
	end
	// set a pin level and hold it for n clocks
	task drive(input logic [11:0] v, input int n);
		@(posedge clk_i);
		pins_o <= v;
		repeat (n) @(posedge clk_i);
	endtask
	// one rising edge on slave select, held well past capture
	task pulse_select;
		@(posedge clk_i);
		pss_o <= 1'b1;
		repeat (4) @(posedge clk_i);
		pss_o <= 1'b0;
		repeat (16) @(posedge clk_i);
	endtask
endmodule

// [tb/io_timer_properties.sv]
// port assertions for the pin conditioning and timer block
// assumes: bound to io_timer_block, one clock, sync reset high
`timescale 1ns/1ns
`include "io_timer_defines.vh"
module io_timer_checker (
	input wire clk_i,
	input wire srst_i,
	input wire ce_i,
	input wire [11:0] pins_i,
	input wire [7:0] addr_i,
	input wire [7:0] wdata_i,
	input wire we_i,
	input wire re_i,
	input wire [7:0] rdata_o,
	input wire asp_rx_stb_i,
	input wire asp_tx_take_i,
	input wire [7:0] asp_tx_data_o,
	input wire asp_tx_valid_o,
	input wire asp_xfer_req_o,
	input wire spi_rx_stb_i,
	input wire spi_xfer_req_o
);
	reg [11:0] pins_q;
	reg [3:0] still;
	reg [7:0] low0;
	wire rd_pin = ce_i && re_i && addr_i == `ADDR_PIN_LO;
	// clocks the pins held still, clocks pin 0 stayed low uncleared
	always @(posedge clk_i) begin
		pins_q <= pins_i;
		if (srst_i || !ce_i || pins_i != pins_q)
			still <= 4'h0;
		else if (still != 4'hf)
			still <= still + 4'h1;
		if (srst_i || !ce_i || pins_i[0] || (we_i && addr_i == `ADDR_LVL_LATCH && wdata_i[0]))
			low0 <= 8'h00;
		else if (low0 != 8'hff)
			low0 <= low0 + 8'h01;
	end
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (srst_i);
	property p_read_idle;
		$past(ce_i) && !$past(re_i) |-> rdata_o == 8'h00;
	endproperty
	a_read_idle: assert property (p_read_idle) else $error("read data not idle");
	property p_pin_sync;
		rd_pin && pins_i == pins_q && still >= 4'h8 |=> rdata_o == $past(pins_i[7:0]);
	endproperty
	a_pin_sync: assert property (p_pin_sync) else $error("pin level wrong");
	property p_two_stage;
		rd_pin && pins_i != pins_q && still >= 4'h8 |=> rdata_o == $past(pins_q[7:0]);
	endproperty
	a_two_stage: assert property (p_two_stage) else $error("pin seen too early");
	property p_level_latch;
		ce_i && re_i && addr_i == `ADDR_LVL_LATCH && low0 >= 8'h78 |=> rdata_o[0];
	endproperty
	a_level_latch: assert property (p_level_latch) else $error("low level missed");
	property p_rx_req;
		ce_i && asp_rx_stb_i |=> asp_xfer_req_o;
	endproperty
	a_rx_req: assert property (p_rx_req) else $error("serial byte not flagged");
	property p_rx_req_spi;
		ce_i && spi_rx_stb_i |=> spi_xfer_req_o;
	endproperty
	a_rx_req_spi: assert property (p_rx_req_spi) else $error("spi byte not flagged");
	property p_req_cause;
		$rose(asp_xfer_req_o) |-> $past(asp_rx_stb_i);
	endproperty
	a_req_cause: assert property (p_req_cause) else $error("request without byte");
	property p_tx_load;
		ce_i && we_i && addr_i == 8'h41 && !asp_tx_valid_o
			|=> asp_tx_valid_o && asp_tx_data_o == $past(wdata_i);
	endproperty
	a_tx_load: assert property (p_tx_load) else $error("tx byte not held");
	property p_tx_hold;
		$fell(asp_tx_valid_o) |-> $past(asp_tx_take_i);
	endproperty
	a_tx_hold: assert property (p_tx_hold) else $error("tx byte dropped");
endmodule

bind io_timer_block io_timer_checker u_io_timer_checker (.clk_i(clk_i), .srst_i(srst_i),
	.ce_i(ce_i), .pins_i(pins_i), .addr_i(addr_i), .wdata_i(wdata_i), .we_i(we_i),
	.re_i(re_i), .rdata_o(rdata_o), .asp_rx_stb_i(asp_rx_stb_i),
	.asp_tx_take_i(asp_tx_take_i), .asp_tx_data_o(asp_tx_data_o),
	.asp_tx_valid_o(asp_tx_valid_o), .asp_xfer_req_o(asp_xfer_req_o),
	.spi_rx_stb_i(spi_rx_stb_i), .spi_xfer_req_o(spi_xfer_req_o));

// [tb/testbench.sv]
// self-checking bench for the pin conditioning and timer block
// assumes: pin_source partner, 250 MHz clock, timer 0 at 0x10
`timescale 1ns/1ns
module testbench;
	reg clk_i, srst_i, we_i, re_i, ce;
	reg [7:0] addr_i, wdata_i;
	reg [1:0] rx_stb, take;
	reg [1:0][7:0] rxd;
	wire [1:0][7:0] txd;
	wire [1:0] txv, xreq;
	wire [11:0] pins;
	wire pss, out0, out1;
	wire [7:0] rdata;
	int err_count, tests_run;
	// ----------------------------------------------------------------
	// partner and design
	// ----------------------------------------------------------------
	pin_source u_pin_source (.clk_i(clk_i), .pins_o(pins), .pss_o(pss));
	io_timer_block #(.WINDOW_CYC(64)) u_io_timer_block (.clk_i(clk_i), .srst_i(srst_i),
		.ce_i(ce), .pins_i(pins), .pss_i(pss), .addr_i(addr_i), .wdata_i(wdata_i),
		.we_i(we_i), .re_i(re_i), .rdata_o(rdata), .tmr0_out_o(out0), .tmr1_out_o(out1),
		.asp_rx_data_i(rxd[0]), .asp_rx_stb_i(rx_stb[0]), .asp_tx_data_o(txd[0]),
		.asp_tx_valid_o(txv[0]), .asp_tx_take_i(take[0]), .asp_xfer_req_o(xreq[0]),
		.spi_rx_data_i(rxd[1]), .spi_rx_stb_i(rx_stb[1]), .spi_tx_data_o(txd[1]),
		.spi_tx_valid_o(txv[1]), .spi_tx_take_i(take[1]), .spi_xfer_req_o(xreq[1]));
	// ----------------------------------------------------------------
	// bus and check tasks
	// ----------------------------------------------------------------
	task chk(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
			err_count++;
		end
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_i);
		we_i <= 1'b1;
		addr_i <= a;
		wdata_i <= d;
		@(posedge clk_i);
		we_i <= 1'b0;
		#1;
	endtask
	task rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk_i);
		re_i <= 1'b1;
		addr_i <= a;
		@(posedge clk_i);
		re_i <= 1'b0;
		#1 d = rdata;
	endtask
	task tick(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask
	// program timer 0 and start it
	task tset(input logic [7:0] md, input logic [7:0] aux, input logic [7:0] ld);
		wr(8'h10, md);
		wr(8'h11, 8'h00);
		wr(8'h12, ld);
		wr(8'h13, 8'h00);
		wr(8'h14, aux);
		wr(8'h15, 8'h00);
		wr(8'h18, 8'h01);
	endtask
	task wrap_up;
		if (err_count == 0 && tests_run > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task t_pins;
		logic [7:0] d;
		u_pin_source.drive(12'h5a3, 16);
		rd(8'h00, d);
		chk(d, 8'ha3);
		rd(8'h01, d);
		chk(d, 8'h05);
		fork
			u_pin_source.drive(12'ha5c, 0);
			rd(8'h00, d);
		join
		chk(d, 8'ha3);
		tick(16);
		rd(8'h00, d);
		chk(d, 8'h5c);
	endtask
	task t_level;
		logic [7:0] d;
		u_pin_source.drive(12'hfff, 60);
		wr(8'h02, 8'hff);
		u_pin_source.drive(12'hffe, 140);
		rd(8'h02, d);
		chk(d[0], 1'b1);
		u_pin_source.drive(12'hfff, 60);
		rd(8'h02, d);
		chk(d[0], 1'b1);
		wr(8'h02, 8'h01);
		tick(60);
		rd(8'h02, d);
		chk(d[0], 1'b0);
	endtask
	task t_pss;
		logic [7:0] d;
		u_pin_source.pulse_select;
		rd(8'h03, d);
		chk(d[0], 1'b1);
		wr(8'h03, 8'h01);
		rd(8'h03, d);
		chk(d[0], 1'b0);
	endtask
	task t_buf(input int b);
		logic [7:0] d, base;
		base = 8'h40 + 8'h04 * b[7:0];
		@(posedge clk_i);
		rxd[b] <= 8'ha5;
		rx_stb[b] <= 1'b1;
		@(posedge clk_i);
		rx_stb[b] <= 1'b0;
		#1 chk(xreq[b], 1'b1);
		rd(base, d);
		chk(d, 8'ha5);
		chk(xreq[b], 1'b0);
		wr(base + 8'h01, 8'h3c);
		chk({txv[b], txd[b]}, 9'h13c);
		@(posedge clk_i);
		take[b] <= 1'b1;
		@(posedge clk_i);
		take[b] <= 1'b0;
		#1 chk(txv[b], 1'b0);
	endtask
	task t_oneshot;
		int n;
		n = 0;
		tset(8'h0a, 8'h00, 8'h05);
		for (int i = 0; i < 40 && out0 !== 1'b1; i++)
			tick(1);
		while (out0 === 1'b1 && n < 100) begin
			tick(1);
			n++;
		end
		chk(n, 16'h000c);
		tick(40);
		chk(out0, 1'b0);
	endtask
	task t_wave;
		logic [7:0] md[4] = '{8'h0b, 8'h0b, 8'h0b, 8'h09};
		logic [7:0] ld[4] = '{8'h00, 8'h03, 8'h0a, 8'h03};
		logic [15:0] ex[4] = '{16'h0000, 16'h0030, 16'h00a0, 16'h0050};
		int n;
		for (int k = 0; k < 4; k++) begin
			tset(md[k], 8'h09, ld[k]);
			tick(40);
			n = 0;
			for (int i = 0; i < 160; i++) begin
				tick(1);
				if (out0 === 1'b1)
					n++;
			end
			chk(n, ex[k]);
		end
	endtask
	task t_high;
		logic [7:0] lo, hi, s;
		u_pin_source.drive(12'hfef, 20);
		tset(8'h01, 8'h00, 8'h00);
		u_pin_source.drive(12'hfef, 20);
		u_pin_source.drive(12'hfff, 40);
		u_pin_source.drive(12'hfef, 40);
		rd(8'h18, s);
		chk(s[0], 1'b1);
		rd(8'h16, lo);
		rd(8'h17, hi);
		chk({hi, lo} >= 16'h0013 && {hi, lo} <= 16'h0015, 1'b1);
		// period mode: 40-cycle pin period, second rise latches it
		tset(8'h02, 8'h00, 8'h00);
		repeat (2) begin
			u_pin_source.drive(12'hfff, 19);
			u_pin_source.drive(12'hfef, 19);
		end
		rd(8'h16, lo);
		rd(8'h17, hi);
		chk({hi, lo} >= 16'h0013 && {hi, lo} <= 16'h0014, 1'b1);
	endtask
	// timer 1 square wave, then a clock-enable freeze
	task t_tmr1;
		logic v;
		int n;
		n = 0;
		wr(8'h20, 8'h09);
		wr(8'h22, 8'h03);
		tick(40);
		for (int i = 0; i < 160; i++) begin
			tick(1);
			if (out1 === 1'b1)
				n++;
		end
		chk(n, 16'h0050);
		@(posedge clk_i);
		ce <= 1'b0;
		#1 v = out1;
		repeat (24) @(posedge clk_i);
		ce <= 1'b1;
		#1 chk(out1, v);
	endtask
	// ----------------------------------------------------------------
	// clock, sequence and watchdog
	// ----------------------------------------------------------------
	initial begin
		clk_i = 1'b0;
		forever #2 clk_i = ~clk_i;
	end
	initial begin
		srst_i <= 1'b1;
		ce = 1'b1;
		we_i = 1'b0;
		re_i = 1'b0;
		addr_i = 8'h00;
		wdata_i = 8'h00;
		rx_stb = 2'h0;
		take = 2'h0;
		rxd = 16'h0000;
		err_count = 0;
		tests_run = 0;
		repeat (5) @(posedge clk_i);
		srst_i <= 1'b0;
		t_pins;
		t_level;
		t_pss;
		t_buf(0);
		t_buf(1);
		t_oneshot;
		t_wave;
		t_high;
		t_tmr1;
		wrap_up;
	end
	initial begin
		repeat (20000) @(posedge clk_i);
		err_count++;
		wrap_up;
	end
endmodule
